/* File: core/dmp_pkg.sv */
// Package of constants and carrier types for the dual-modulus ten/eleven prescaler.
package dmp_pkg;
	// Counter width and the two division ratios.
	localparam int DMP_CNT_W = 4;
	localparam logic [3:0] DMP_DIV_TEN = 4'ha;
	localparam logic [3:0] DMP_DIV_ELEVEN = 4'hb;
	// Count state that preset forces: the eleventh state, index ten from zero.
	localparam logic [3:0] DMP_PRESET_STATE = 4'ha;
	// Count state after reset.
	localparam logic [3:0] DMP_RESET_STATE = 4'h0;
	// Count state at which the modulus is sampled, the last state of a ten cycle.
	localparam logic [3:0] DMP_SAMPLE_STATE = 4'h9;
	// First count state in which the true output is high.
	localparam logic [3:0] DMP_HIGH_FROM = 4'h5;
	// Synchroniser depth for pin inputs.
	localparam int DMP_SYNC_STAGES = 2;
	// Mode control set-up and release time the controller must honour, in ns.
	localparam int DMP_MODE_SETUP_NS = 4;
	localparam int DMP_CLK_PERIOD_PS = 25000;
	// Cycles of margin for the set-up time, least time so rounded up, at least one.
	localparam int DMP_MODE_SETUP_CYC_RAW = (DMP_MODE_SETUP_NS * 1000 + DMP_CLK_PERIOD_PS - 1) / DMP_CLK_PERIOD_PS;
	localparam int DMP_MODE_SETUP_CYC = (DMP_MODE_SETUP_CYC_RAW < 1) ? 1 : DMP_MODE_SETUP_CYC_RAW;

	// Inputs from the synthesiser control logic, all pins.
	typedef struct packed {
		logic mode_select_a;
		logic mode_select_b;
		logic preset_eleven;
		logic counted_input_clock;
	} dmp_pins_t;

	// Complementary divided outputs.
	typedef struct packed {
		logic divided_output;
		logic divided_output_n;
	} dmp_out_t;
endpackage

/* File: core/dmp_prescaler.sv */
// Dual-modulus divide-by-ten/eleven prescaler counting edges of a sampled pin clock.
//
// Overview of operation
// - Either mode select high divides by ten.
// - Both mode selects low divides by eleven.
// - Preset high forces the eleventh count state.
// - Preset acts without clock edge, dominates clock.
// - True and complementary divided outputs.
`timescale 1ns/1ps
module dmp_prescaler
	import dmp_pkg::*;
(
	// System clock and synchronous active-low reset.
	input wire logic clk,
	input wire logic rstn,
	// Pin inputs from the synthesiser control logic.
	input wire dmp_pins_t pins,
	// Divided outputs.
	output dmp_out_t dout
);
	typedef enum logic [2:0] {
		DMP_ST_COUNT = 3'b001,
		DMP_ST_PRESET = 3'b010,
		DMP_ST_IDLE = 3'b100
	} dmp_state_t;

	dmp_pins_t pins_s;
	logic clk_in_d_ff;
	logic rise;
	logic ten_sel;
	logic [DMP_CNT_W-1:0] cnt_ff;
	logic [DMP_CNT_W-1:0] nxt_cnt;
	dmp_state_t state_ff;
	dmp_state_t nxt_state;
	logic q_ff;
	logic q_n_ff;
	logic preset_raw;

	// All pins cross into the system clock through two flops before use.
	dmp_sync #(
		.WIDTH(4)
	) u_sync (
		.clk(clk),
		.rstn(rstn),
		.async_in(pins),
		.sync_out(pins_s)
	);

	// Preset is read from its synchronised copy so the counter can be forced without a counted edge.
	// The raw pin reaches only the synchroniser flops; preset_raw is taken from pins_s.
	assign preset_raw = pins_s.preset_eleven;

	// Rising edges of the counted clock, detected on the synchronised copy.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			clk_in_d_ff <= 1'b0;
		end else begin
			clk_in_d_ff <= pins_s.counted_input_clock;
		end
	end
	assign rise = pins_s.counted_input_clock & ~clk_in_d_ff;

	// Ten when either select is high, eleven only when both are low.
	assign ten_sel = pins_s.mode_select_a | pins_s.mode_select_b;

	// The controller keeps the selects stable ahead of the counted edge; the sync
	// delay is constant so the sampled value still belongs to that edge.

	// Control state: preset overrides counting for as long as it is held.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			DMP_ST_IDLE: begin
				nxt_state = DMP_ST_COUNT;
			end
			DMP_ST_COUNT: begin
				if (preset_raw) begin
					nxt_state = DMP_ST_PRESET;
				end
			end
			DMP_ST_PRESET: begin
				if (!preset_raw) begin
					nxt_state = DMP_ST_COUNT;
				end
			end
			default: begin
				nxt_state = DMP_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_ff <= DMP_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Next count: preset wins over any counted edge. The modulus is read only on the
	// rise that leaves the sample state, so it decides this very period and no other.
	// State ten is reached only in eleven mode or by preset; from there it wraps to zero.
	always_comb begin
		nxt_cnt = cnt_ff;
		if (preset_raw) begin
			nxt_cnt = DMP_PRESET_STATE;
		end else if (rise) begin
			if (cnt_ff == DMP_SAMPLE_STATE) begin
				nxt_cnt = ten_sel ? DMP_RESET_STATE : (cnt_ff + 4'h1);
			end else if (cnt_ff >= (DMP_DIV_ELEVEN - 4'h1)) begin
				nxt_cnt = DMP_RESET_STATE;
			end else begin
				nxt_cnt = cnt_ff + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_ff <= DMP_RESET_STATE;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Outputs are registered from the next count so they follow the counter
	// without a further cycle; the complement is its own flop, never a gate.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			q_ff <= 1'b0;
			q_n_ff <= 1'b1;
		end else begin
			q_ff <= (nxt_cnt >= DMP_HIGH_FROM);
			q_n_ff <= (nxt_cnt < DMP_HIGH_FROM);
		end
	end

	assign dout.divided_output = q_ff;
	assign dout.divided_output_n = q_n_ff;
endmodule

/* File: core/dmp_sync.sv */
// Two-flip-flop synchroniser, one per bit, for pin inputs.
`timescale 1ns/1ps
module dmp_sync
	import dmp_pkg::*;
#(
	parameter int WIDTH = 4
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Asynchronous bits in, synchronised bits out.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// Each bit passes two flops; only the second stage is read beyond this module.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rstn) begin
					meta_ff[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_ff[i] <= async_in[i];
					sync_out[i] <= meta_ff[i];
				end
			end
		end
	endgenerate
endmodule

/* File: dv/dmp_ctl_model.sv */
// Model of the synthesiser control logic that drives the prescaler pins.
`timescale 1ns/1ps
module dmp_ctl_model
	import dmp_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Requests from the bench.
	input wire logic [1:0] mode_req,
	input wire logic preset_req,
	// Pins.
	output dmp_pins_t pins
);
	logic [2:0] ph_ff;
	// Counted clock of eight cycles; modes move on its fall, so set-up before the next rise is ample.
	always_ff @(posedge clk) begin
		ph_ff <= rstn ? ph_ff + 3'h1 : 3'h0;
		pins.counted_input_clock <= rstn & ph_ff[2];
		pins.preset_eleven <= preset_req;
		if (!rstn || (ph_ff == 3'h0 && pins.counted_input_clock)) begin
			{pins.mode_select_a, pins.mode_select_b} <= mode_req;
		end
	end
endmodule

/* File: dv/dmp_prescaler_props.sv */
// Concurrent checks on the prescaler ports.
`timescale 1ns/1ps
module dmp_prescaler_props
	import dmp_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Watched ports.
	input wire dmp_pins_t pins,
	input wire dmp_out_t dout
);
	logic [4:0] rc_ff;
	logic ok_ff;
	wire logic any_mode = pins.mode_select_a | pins.mode_select_b;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Counted rises per output period; a preset breaks the period, so it voids the count.
	always_ff @(posedge clk) begin
		ok_ff <= (rstn && !pins.preset_eleven && !$changed(any_mode)) && (ok_ff || $rose(dout.divided_output));
		if ($rose(dout.divided_output)) begin
			rc_ff <= 5'h0;
		end else if ($rose(pins.counted_input_clock)) begin
			rc_ff <= rc_ff + 5'h1;
		end
	end
	chk_ten_ratio: assert property ($rose(dout.divided_output) && ok_ff && any_mode |-> rc_ff == 5'ha)
		else $error("ten ratio wrong");
	chk_eleven_ratio: assert property ($rose(dout.divided_output) && ok_ff && !any_mode |-> rc_ff == 5'hb)
		else $error("eleven ratio wrong");
	chk_preset_sets: assert property ($rose(pins.preset_eleven) |-> ##[1:3] dout.divided_output)
		else $error("preset did not set");
	chk_preset_holds: assert property (pins.preset_eleven [*5] |-> dout.divided_output)
		else $error("preset did not hold");
	chk_out_compl: assert property (dout.divided_output_n == !dout.divided_output)
		else $error("outputs not complementary");
	chk_low_span: assert property ($fell(dout.divided_output) |-> !dout.divided_output [*8])
		else $error("low span short");
endmodule
bind dmp_prescaler dmp_prescaler_props u_props (.clk(clk), .rstn(rstn), .pins(pins), .dout(dout));

/* File: dv/tb_dmp_prescaler.sv */
// Self-checking bench for the prescaler.
`timescale 1ns/1ps
module tb_dmp_prescaler;
	import dmp_pkg::*;
	`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
		$display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
	logic clk;
	logic rstn;
	logic [1:0] mode_req;
	logic preset_req;
	dmp_pins_t pins;
	dmp_out_t dout;
	int bad_count;
	int cmp_count;
	int n;
	dmp_ctl_model ctl (.clk(clk), .rstn(rstn), .mode_req(mode_req), .preset_req(preset_req), .pins(pins));
	dmp_prescaler dut (.clk(clk), .rstn(rstn), .pins(pins), .dout(dout));
	// System clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Cycles to the next output rise, sampled on falling edges so updates have landed; bounded.
	task automatic to_rise(output int c);
		c = 0;
		while (dout.divided_output !== 1'b0 && c < 300) begin @(negedge clk); c++; end
		while (dout.divided_output !== 1'b1 && c < 300) begin @(negedge clk); c++; end
	endtask
	// Period of the output in system cycles for one mode setting, counted clock being eight cycles.
	task automatic t_ratio(input logic [1:0] m, input int exp_n);
		@(posedge clk) mode_req <= m;
		repeat (2) to_rise(n);
		to_rise(n);
		`CHK("period", exp_n * 8, n)
		`CHK("compl", ~dout.divided_output, dout.divided_output_n)
	endtask
	// Preset forces the eleventh state, holds it against counted rises, and the next rise wraps to zero.
	task automatic t_preset();
		@(posedge clk) preset_req <= 1'b1;
		repeat (6) @(negedge clk);
		`CHK("preset out", 1'b1, dout.divided_output)
		repeat (40) @(negedge clk);
		`CHK("preset hold", 1'b1, dout.divided_output)
		@(posedge clk) preset_req <= 1'b0;
		repeat (14) @(negedge clk);
		`CHK("wrap", 1'b0, dout.divided_output)
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run of under two thousand cycles.
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
	// Main sequence.
	initial begin
		rstn = 1'b0;
		mode_req = 2'h3;
		preset_req = 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk) `CHK("reset out", 1'b0, dout.divided_output)
		`CHK("reset out_n", 1'b1, dout.divided_output_n)
		@(posedge clk) rstn <= 1'b1;
		t_ratio(2'h0, 11);
		t_ratio(2'h2, 10);
		t_ratio(2'h0, 11);
		t_ratio(2'h1, 10);
		t_ratio(2'h3, 10);
		t_preset();
		t_ratio(2'h0, 11);
		wrap_up();
	end
endmodule
